// ==== design/sdd_pkg.sv ====
// package of constants and types for the segment display driver
package sdd_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [1:0] ADDR_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_POINTER = 2'h1;
   localparam logic [1:0] ADDR_WINDOW  = 2'h2;
   localparam logic [1:0] ADDR_PUMP    = 2'h3;

   // ****************************************
   // field positions
   // ****************************************
   localparam int BIAS_BIT      = 7;
   localparam int DUTY_HI_BIT   = 6;
   localparam int DUTY_LO_BIT   = 5;
   localparam int ENABLE_BIT    = 4;
   localparam int STYLE_BIT     = 2;
   localparam int FRAME_HI_BIT  = 1;
   localparam int FRAME_LO_BIT  = 0;
   localparam int PUMP_HI_BIT   = 2;
   localparam int PUMP_LO_BIT   = 1;

   // ****************************************
   // reset values and write masks
   // ****************************************
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [4:0] POINTER_RESET = 5'h00;
   localparam logic [7:0] PUMP_RESET    = 8'h00;
   localparam logic [7:0] CONTROL_MASK  = 8'hf7;
   localparam logic [7:0] PUMP_MASK     = 8'h06;

   // ****************************************
   // geometry and timing counts
   // ****************************************
   localparam int SEGMENTS = 32;
   localparam int COMMONS  = 4;
   localparam logic [8:0] FRAME_HALF_0    = 9'd256;
   localparam logic [8:0] FRAME_HALF_1    = 9'd280;
   localparam logic [8:0] FRAME_HALF_2    = 9'd304;
   localparam logic [8:0] FRAME_HALF_3    = 9'd232;
   localparam logic [8:0] FRAME_THIRD_0   = 9'd172;
   localparam logic [8:0] FRAME_THIRD_1   = 9'd188;
   localparam logic [8:0] FRAME_THIRD_2   = 9'd204;
   localparam logic [8:0] FRAME_THIRD_3   = 9'd156;
   localparam logic [8:0] FRAME_QUARTER_0 = 9'd128;
   localparam logic [8:0] FRAME_QUARTER_1 = 9'd140;
   localparam logic [8:0] FRAME_QUARTER_2 = 9'd152;
   localparam logic [8:0] FRAME_QUARTER_3 = 9'd116;
   localparam logic [3:0] PUMP_DIV_4  = 4'h1;
   localparam logic [3:0] PUMP_DIV_8  = 4'h3;
   localparam logic [3:0] PUMP_DIV_16 = 4'h7;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      SDD_DUTY_HALF    = 2'b00,
      SDD_DUTY_THIRD   = 2'b01,
      SDD_DUTY_QUARTER = 2'b10
   } sdd_duty_e;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sdd_bus_s;

   // per common line: drive active and phase level
   typedef struct packed {
      logic [3:0]  com_on;
      logic [3:0]  com_level;
      logic [31:0] seg_level;
   } sdd_drive_s;

endpackage : sdd_pkg

// ==== design/sdd_top.sv ====
// segment display driver: registers, display ram, scan timing and drive levels
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module sdd_top (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        clk_en,
   input  wire logic        sub_osc_tick,
   input  wire logic [1:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic      [3:0]  common_on,
   output logic      [3:0]  common_level,
   output logic      [31:0] segment_level,
   output logic             bias_third,
   output logic             pump_clk
);

   // ****************************************
   // register file
   // ****************************************
   sdd_pkg::sdd_bus_s bus;
   logic [7:0]  display_control;
   logic [4:0]  display_ram_index;
   logic [7:0]  system_pump_clock_control;
   logic [3:0]  display_ram [0:sdd_pkg::SEGMENTS-1];
   logic [7:0]  next_rdata;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ****************************************
   // write decode
   // ****************************************
   // strobes are qualified by the enable here, so a frozen core takes no write
   logic wr_control;
   logic wr_pointer;
   logic wr_window;
   logic wr_pump;

   assign wr_control = clk_en && bus.wr && (bus.addr == sdd_pkg::ADDR_CONTROL);
   assign wr_pointer = clk_en && bus.wr && (bus.addr == sdd_pkg::ADDR_POINTER);
   assign wr_window  = clk_en && bus.wr && (bus.addr == sdd_pkg::ADDR_WINDOW);
   assign wr_pump    = clk_en && bus.wr && (bus.addr == sdd_pkg::ADDR_PUMP);

   wire       display_enable  = display_control[sdd_pkg::ENABLE_BIT];
   wire       duty_select_high = display_control[sdd_pkg::DUTY_HI_BIT];
   wire       duty_select_low  = display_control[sdd_pkg::DUTY_LO_BIT];
   wire       bias_select     = display_control[sdd_pkg::BIAS_BIT];
   wire       waveform_style  = display_control[sdd_pkg::STYLE_BIT];
   wire [1:0] frame_rate      = {display_control[sdd_pkg::FRAME_HI_BIT],
                                 display_control[sdd_pkg::FRAME_LO_BIT]};
   wire [1:0] pump_clock_sel  = {system_pump_clock_control[sdd_pkg::PUMP_HI_BIT],
                                 system_pump_clock_control[sdd_pkg::PUMP_LO_BIT]};

   // ****************************************
   // duty decode
   // ****************************************
   sdd_pkg::sdd_duty_e duty;
   always_comb begin
      if (duty_select_high)
         duty = sdd_pkg::SDD_DUTY_QUARTER;
      else if (duty_select_low)
         duty = sdd_pkg::SDD_DUTY_THIRD;
      else
         duty = sdd_pkg::SDD_DUTY_HALF;
   end

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         display_control <= sdd_pkg::CONTROL_RESET;
      end else if (wr_control) begin
         display_control <= bus.wdata & sdd_pkg::CONTROL_MASK;
      end
   end

   // ****************************************
   // ram pointer
   // ****************************************
   // upper pointer bits are dropped, not stored
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         display_ram_index <= sdd_pkg::POINTER_RESET;
      end else if (wr_pointer) begin
         display_ram_index <= bus.wdata[4:0];
      end
   end

   // ****************************************
   // pump select register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         system_pump_clock_control <= sdd_pkg::PUMP_RESET;
      end else if (wr_pump) begin
         system_pump_clock_control <= bus.wdata & sdd_pkg::PUMP_MASK;
      end
   end

   // ****************************************
   // display ram
   // ****************************************
   // ram has no reset; software loads it before enabling
   always_ff @(posedge core_clk) begin
      if (wr_window) begin
         display_ram[display_ram_index] <= bus.wdata[3:0];
      end
   end

   // ****************************************
   // read back
   // ****************************************
   always_comb begin
      next_rdata = 8'h00;
      unique case (bus.addr)
         sdd_pkg::ADDR_CONTROL: next_rdata = display_control;
         sdd_pkg::ADDR_POINTER: next_rdata = {3'b000, display_ram_index};
         sdd_pkg::ADDR_WINDOW:  next_rdata = {4'h0, display_ram[display_ram_index]};
         sdd_pkg::ADDR_PUMP:    next_rdata = system_pump_clock_control;
      endcase
   end

   // ****************************************
   // read data register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= bus.rd ? next_rdata : 8'h00;
      end
   end

   // ****************************************
   // scan timing on the sub-oscillator tick
   // ****************************************
   logic [8:0] phase_len;
   logic [1:0] last_common;
   logic [8:0] tick_count;
   logic [1:0] active_common;
   logic       frame_half;

   // ****************************************
   // phase length
   // ****************************************
   always_comb begin
      phase_len = sdd_pkg::FRAME_HALF_0;
      unique case (duty)
         sdd_pkg::SDD_DUTY_HALF: begin
            unique case (frame_rate)
               2'b00: phase_len = sdd_pkg::FRAME_HALF_0;
               2'b01: phase_len = sdd_pkg::FRAME_HALF_1;
               2'b10: phase_len = sdd_pkg::FRAME_HALF_2;
               2'b11: phase_len = sdd_pkg::FRAME_HALF_3;
            endcase
         end
         sdd_pkg::SDD_DUTY_THIRD: begin
            unique case (frame_rate)
               2'b00: phase_len = sdd_pkg::FRAME_THIRD_0;
               2'b01: phase_len = sdd_pkg::FRAME_THIRD_1;
               2'b10: phase_len = sdd_pkg::FRAME_THIRD_2;
               2'b11: phase_len = sdd_pkg::FRAME_THIRD_3;
            endcase
         end
         sdd_pkg::SDD_DUTY_QUARTER: begin
            unique case (frame_rate)
               2'b00: phase_len = sdd_pkg::FRAME_QUARTER_0;
               2'b01: phase_len = sdd_pkg::FRAME_QUARTER_1;
               2'b10: phase_len = sdd_pkg::FRAME_QUARTER_2;
               2'b11: phase_len = sdd_pkg::FRAME_QUARTER_3;
            endcase
         end
         default: phase_len = sdd_pkg::FRAME_HALF_0;
      endcase
   end

   // ****************************************
   // common count
   // ****************************************
   always_comb begin
      unique case (duty)
         sdd_pkg::SDD_DUTY_HALF:    last_common = 2'd1;
         sdd_pkg::SDD_DUTY_THIRD:   last_common = 2'd2;
         sdd_pkg::SDD_DUTY_QUARTER: last_common = 2'd3;
         default:                   last_common = 2'd1;
      endcase
   end

   // ****************************************
   // scan counters
   // ****************************************
   // each common phase lasts phase_len ticks, type B flips polarity per frame
   // holding phase 0 while off keeps a re-enabled panel from starting mid frame
   always_ff @(posedge core_clk) begin
      if (!resetn || !display_enable) begin
         tick_count    <= 9'd0;
         active_common <= 2'd0;
         frame_half    <= 1'b0;
      end else if (clk_en && sub_osc_tick) begin
         if (tick_count == phase_len - 9'd1) begin
            tick_count <= 9'd0;
            if (active_common >= last_common) begin
               active_common <= 2'd0;
               frame_half    <= ~frame_half;
            end else begin
               active_common <= active_common + 2'd1;
            end
         end else begin
            tick_count <= tick_count + 9'd1;
         end
      end
   end

   // ****************************************
   // drive levels
   // ****************************************
   // type A inverts within every phase at half count, type B per frame
   wire [8:0] half_len   = {1'b0, phase_len[8:1]};
   wire       polarity   = waveform_style ? frame_half : (tick_count >= half_len);
   sdd_pkg::sdd_drive_s next_drive;
   logic [31:0] seg_level;

   // ****************************************
   // segment cells
   // ****************************************
   for (genvar s = 0; s < sdd_pkg::SEGMENTS; s++) begin : g_seg
      sdd_seg_cell #(
         .COMMONS       (sdd_pkg::COMMONS)
      ) u_cell (
         .dots          (display_ram[s]),
         .active_common (active_common),
         .polarity      (polarity),
         .enable        (display_enable),
         .level         (seg_level[s])
      );
   end

   always_comb begin
      next_drive = '0;
      if (display_enable) begin
         for (int c = 0; c < sdd_pkg::COMMONS; c++) begin
            next_drive.com_on[c]    = (2'(c) == active_common) && (2'(c) <= last_common);
            next_drive.com_level[c] = polarity;
         end
         next_drive.seg_level = seg_level;
      end
   end

   // ****************************************
   // output registers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         common_on     <= 4'h0;
         common_level  <= 4'h0;
         segment_level <= 32'h0000_0000;
         bias_third    <= 1'b0;
      end else if (clk_en) begin
         common_on     <= next_drive.com_on;
         common_level  <= next_drive.com_level;
         segment_level <= next_drive.seg_level;
         bias_third    <= bias_select;
      end
   end

   // ****************************************
   // charge pump clock
   // ****************************************
   logic [3:0] pump_count;
   logic [3:0] pump_limit;
   always_comb begin
      unique case (pump_clock_sel)
         2'b00: pump_limit = 4'h0;
         2'b01: pump_limit = sdd_pkg::PUMP_DIV_4;
         2'b10: pump_limit = sdd_pkg::PUMP_DIV_8;
         2'b11: pump_limit = sdd_pkg::PUMP_DIV_16;
      endcase
   end

   // ****************************************
   // pump divider
   // ****************************************
   // divided rates toggle every limit+1 ticks, so the period is twice that
   always_ff @(posedge core_clk) begin
      if (!resetn || !display_enable) begin
         pump_count <= 4'h0;
         pump_clk   <= 1'b0;
      end else if (clk_en) begin
         if (pump_clock_sel == 2'b00) begin
            // full rate: a pulse per tick is the only Fs clock a tick can give
            pump_count <= 4'h0;
            pump_clk   <= sub_osc_tick;
         end else if (sub_osc_tick) begin
            if (pump_count >= pump_limit) begin
               pump_count <= 4'h0;
               pump_clk   <= ~pump_clk;
            end else begin
               pump_count <= pump_count + 4'h1;
            end
         end
      end
   end

endmodule : sdd_top

// ****************************************
// one segment line
// ****************************************
// the same small cell serves all 32 lines, so one line proven is all proven
module sdd_seg_cell #(
   parameter int COMMONS = 4
) (
   input  wire logic [COMMONS-1:0] dots,
   input  wire logic [1:0]         active_common,
   input  wire logic               polarity,
   input  wire logic               enable,
   output logic                    level
);
   always_comb begin
      level = 1'b0;
      if (enable) begin
         level = dots[active_common] ^ polarity;
      end
   end
endmodule : sdd_seg_cell

// ==== verif/sdd_glass_model.sv ====
// glass panel model: keeps the dots the scan lights
`timescale 1ns/1ps
module sdd_glass_model (
   input  wire logic             core_clk,
   input  wire logic [3:0]       common_on,
   input  wire logic [3:0]       common_level,
   input  wire logic [31:0]      segment_level,
   output logic      [3:0][31:0] dots
);
   // a dot lights while its segment differs from the active common
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < 4; c++) begin
         if (common_on[c]) dots[c] <= segment_level ^ {32{common_level[c]}};
      end
   end
endmodule : sdd_glass_model

// ==== verif/sdd_top_monitor.sv ====
// port checker for the segment display driver
`timescale 1ns/1ps
module sdd_top_monitor (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        clk_en,
   input wire logic [1:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [3:0]  common_on,
   input wire logic [3:0]  common_level,
   input wire logic [31:0] segment_level,
   input wire logic        bias_third,
   input wire logic        pump_clk
);
   logic       en_q;
   logic [4:0] ptr_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ****
   // shadow of what software wrote
   // ****
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         en_q  <= 1'b0;
         ptr_q <= 5'h00;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == sdd_pkg::ADDR_CONTROL) en_q <= reg_wdata[4];
         if (reg_addr == sdd_pkg::ADDR_POINTER) ptr_q <= reg_wdata[4:0];
      end
   end
   sequence rd_s(logic [1:0] a);
      clk_en && reg_rd && reg_addr == a;
   endsequence
   sequence on_wr_s;
      clk_en && reg_wr && reg_addr == sdd_pkg::ADDR_CONTROL && reg_wdata[4];
   endsequence
   disabled_ground_a: assert property (!en_q [*2] |-> (common_on | common_level) == 4'h0
      && segment_level == 32'h0 && !pump_clk) else $error("drive not grounded");
   rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   ptr_echo_a: assert property (rd_s(sdd_pkg::ADDR_POINTER) |=>
      reg_rdata == {3'h0, $past(ptr_q)}) else $error("pointer read wrong");
   win_high_a: assert property (rd_s(sdd_pkg::ADDR_WINDOW) |=> reg_rdata[7:4] == 4'h0)
      else $error("window upper bits set");
   ctl_bit3_a: assert property (rd_s(sdd_pkg::ADDR_CONTROL) |=> !reg_rdata[3])
      else $error("control bit 3 set");
   pump_mask_a: assert property (rd_s(sdd_pkg::ADDR_PUMP) |=>
      (reg_rdata & ~sdd_pkg::PUMP_MASK) == 8'h00) else $error("pump spare bits set");
   bias_copy_a: assert property (on_wr_s |-> ##2 bias_third == $past(reg_wdata[7], 2))
      else $error("bias select wrong");
   single_common_a: assert property (common_on != 4'h0 |-> $onehot(common_on)
      && (common_level == 4'h0 || common_level == 4'hf)) else $error("scan not one-hot");
endmodule : sdd_top_monitor
bind sdd_top sdd_top_monitor u_mon (.core_clk, .resetn, .clk_en, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .common_on, .common_level, .segment_level, .bias_third,
   .pump_clk);

// ==== verif/sdd_top_bench.sv ====
// bench for the segment display driver
`timescale 1ns/1ps
module sdd_top_bench;
   logic             core_clk, resetn, clk_en, tick, reg_wr, reg_rd, pump_clk, bias_third;
   logic [1:0]       reg_addr, d;
   logic [4:0]       sv;
   logic [7:0]       reg_wdata, reg_rdata, rd_val;
   logic [3:0]       common_on, common_level, lvl1;
   logic [31:0]      segment_level;
   logic [3:0][31:0] dots;
   int               fails, checks_done, cyc, n, cnt, dut;
   sdd_top u_dut (.core_clk, .resetn, .clk_en, .sub_osc_tick(tick), .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .common_on, .common_level, .segment_level,
      .bias_third, .pump_clk);
   sdd_glass_model u_glass (.core_clk, .common_on, .common_level, .segment_level, .dots);
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ****
   // one sub-oscillator tick every second cycle
   // ****
   always @(posedge core_clk) begin
      tick <= resetn ? ~tick : 1'b0;
      cyc++;
      if (cyc == 60000) begin
         fails++;
         final_report();
      end
   end
   task automatic bus(input logic w, r, input logic [1:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr    <= w;
      reg_rd    <= r;
      reg_addr  <= a;
      reg_wdata <= v;
   endtask : bus
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      bus(1'b1, 1'b0, a, v);
      bus(1'b0, 1'b0, a, v);
   endtask : wr
   task automatic rd(input logic [1:0] a);
      bus(1'b0, 1'b1, a, 8'h00);
      bus(1'b0, 1'b0, a, 8'h00);
      #1;
      rd_val = reg_rdata;
   endtask : rd
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic [3:0] probe(input bit sel);
      return sel ? {3'h0, pump_clk} : common_on;
   endfunction : probe
   // bounded: a stuck scan shows as a wrong count
   task automatic wait_chg(input bit sel, output int k);
      logic [3:0] v;
      v = probe(sel);
      k = 0;
      while (probe(sel) === v && k < 2000) begin
         @(posedge core_clk);
         #1;
         k++;
      end
   endtask : wait_chg
   function automatic int fcnt(input logic [1:0] dc, f);
      int t [3][4] = '{'{256, 280, 304, 232}, '{172, 188, 204, 156}, '{128, 140, 152, 116}};
      return t[dc[1] ? 2 : int'(dc[0])][f];
   endfunction : fcnt
   function automatic logic [31:0] segexp(input int c);
      logic [4:0] s5;
      for (int s = 0; s < 32; s++) begin
         s5 = 5'(s);
         segexp[s] = s5[c] ^ s5[4];
      end
   endfunction : segexp
   task automatic final_report;
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 13'h0;
      clk_en = 1'b1;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         if (a != 2) rd(2'(a));
         if (a != 2) chk("reset", rd_val, 8'h00);
      end
      wr(sdd_pkg::ADDR_POINTER, 8'hff);
      rd(sdd_pkg::ADDR_POINTER);
      chk("ptr", rd_val, 8'h1f);
      clk_en <= 1'b0;
      wr(sdd_pkg::ADDR_POINTER, 8'h05);
      clk_en <= 1'b1;
      rd(sdd_pkg::ADDR_POINTER);
      chk("frozen", rd_val, 8'h1f);
      wr(sdd_pkg::ADDR_CONTROL, 8'h0f);
      rd(sdd_pkg::ADDR_CONTROL);
      chk("ctl", rd_val, 8'h07);
      wr(sdd_pkg::ADDR_PUMP, 8'hff);
      rd(sdd_pkg::ADDR_PUMP);
      chk("pump reg", rd_val, 8'h06);
      for (int s = 0; s < 32; s++) begin
         sv = 5'(s);
         wr(sdd_pkg::ADDR_POINTER, {3'h0, sv});
         wr(sdd_pkg::ADDR_WINDOW, {4'hf, sv[3:0] ^ {4{sv[4]}}});
         rd(sdd_pkg::ADDR_WINDOW);
         chk("ram", rd_val, {4'h0, sv[3:0] ^ {4{sv[4]}}});
      end
      for (int i = 0; i < 4; i++) begin
         d = 2'(i);
         dut = d[1] ? 4 : 2 + d[0];
         cnt = fcnt(d, d);
         wr(sdd_pkg::ADDR_CONTROL, 8'h00);
         repeat (4) @(posedge core_clk);
         #1;
         chk("off", segment_level | common_on | common_level | pump_clk, 32'h0);
         wr(sdd_pkg::ADDR_CONTROL, {i[0], d, 1'b1, 1'b0, i == 3, d});
         wait_chg(0, n);
         wait_chg(0, n);
         for (int p = 1; p <= dut; p++) begin
            chk("com", common_on, 4'h1 << (p % dut));
            chk("seg", segment_level, segexp(p % dut) ^ {32{common_level[0]}});
            if (i < 3) chk("lvl", common_level, 4'h0);
            if (p == 1) lvl1 = common_level;
            if (p == 1) chk("bias", bias_third, i[0]);
            if (p == dut && i == 3) chk("lvl b", common_level, lvl1 ^ 4'hf);
            if (p == 1 && i < 3) begin
               repeat (cnt + 2) @(posedge core_clk);
               #1;
               chk("half", common_level, 4'hf);
            end
            wait_chg(0, n);
            chk("phase", n, (p == 1 && i < 3) ? cnt - 2 : 2 * cnt);
         end
         for (int c = 0; c < dut; c++) chk("glass", dots[c], segexp(c));
      end
      for (int k = 0; k < 4; k++) begin
         wr(sdd_pkg::ADDR_PUMP, {5'h0, 2'(k), 1'b0});
         repeat (3) wait_chg(1, n);
         chk("pump", n, k == 0 ? 1 : 2 << k);
      end
      final_report();
   end
endmodule : sdd_top_bench
